// *** hw/tpf_pkg.sv ***
/*
  Shared constants and types for the touch controller digital block: the
  serial slave address, command field layout, function codes, setup bits,
  filter size and conversion timing.
  Assumes a 50 MHz core clock and a separate free-running link clock.
*/
package tpf_pkg;

  // Fixed upper five bits of the seven-bit slave address.
  localparam logic [4:0] ADDR_FIXED = 5'h12;

  // Command byte field positions.
  localparam int CMD_FN_LSB = 4;
  localparam int CMD_PM_LSB = 2;
  localparam int CMD_RES_BIT = 1;

  // Function select codes.
  localparam logic [3:0] FN_SETUP = 4'hB;
  localparam logic [3:0] FN_XDRV = 4'h8;
  localparam logic [3:0] FN_YDRV = 4'h9;
  localparam logic [3:0] FN_YXDRV = 4'hA;
  localparam logic [3:0] FN_MEAS_X = 4'hC;
  localparam logic [3:0] FN_MEAS_Y = 4'hD;
  localparam logic [3:0] FN_MEAS_Z1 = 4'hE;
  localparam logic [3:0] FN_MEAS_Z2 = 4'hF;

  // Setup nibble bit positions.
  localparam int SETUP_PULLUP_BIT = 0;
  localparam int SETUP_BYPASS_BIT = 1;

  // Reset values of the pen and setup state.
  localparam logic [1:0] PM_RESET = 2'h0;
  localparam logic PULLUP_HI_RESET = 1'b0;
  localparam logic BYPASS_RESET = 1'b0;

  // Converter data width and filter geometry.
  localparam int ADC_W = 12;
  localparam int MAV_TAPS = 7;
  localparam int MAV_MID = 3;

  // Conversion time until pen detection returns, per resolution.
  localparam int CORE_CLK_MHZ = 50;
  localparam int CONV12_TIME_US = 100;
  localparam int CONV8_TIME_US = 50;
  localparam int CONV12_CYCLES = CONV12_TIME_US * CORE_CLK_MHZ;
  localparam int CONV8_CYCLES = CONV8_TIME_US * CORE_CLK_MHZ;
  localparam int CONV_CNT_W = 16;

  // Link-side slave states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_ADDR = 3'h1,
    LK_AACK = 3'h3,
    LK_RX = 3'h2,
    LK_RACK = 3'h6,
    LK_TX = 3'h7,
    LK_TACK = 3'h5,
    LK_WAIT = 3'h4
  } tpf_link_st_t;

endpackage : tpf_pkg

// *** hw/tpf_mav_filter.sv ***
/*
  Median-plus-average filter: gathers a set of conversion results, ranks
  them and returns the truncated mean of the middle three, or passes a
  single result through when bypassed.
  Assumes samples arrive one at a time on the core clock after a clear.
*/
`timescale 1ns/1ps
module tpf_mav_filter
  import tpf_pkg::*;
#(
  parameter int W = ADC_W,
  parameter int N = MAV_TAPS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic clear,
  input wire logic bypass,
  // Sample input.
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  // Result output.
  output logic need_more,
  output logic out_valid,
  output logic [W-1:0] out_data
);

  // All filter state in one record.
  typedef struct packed {
    logic [N-1:0][W-1:0] smp;
    logic [3:0] cnt;
    logic done;
    logic out_valid;
    logic [W-1:0] out_data;
  } tpf_mav_st_t;

  tpf_mav_st_t r_reg;
  tpf_mav_st_t r_next;
  logic [3:0] need_cnt; // Samples wanted for this run.
  logic [W+1:0] mid_sum; // Sum of the three middle-ranked samples.

  assign need_cnt = bypass ? 4'h1 : 4'(N);
  assign need_more = !r_reg.done && (r_reg.cnt < need_cnt);
  assign out_valid = r_reg.out_valid;
  assign out_data = r_reg.out_data;

  ////////////////////////////////////////////////////////////////////////////
  // Ranking: each sample's rank is the number of samples below it, ties
  // broken by position, so the ranks always form a permutation and exactly
  // three samples land in the middle band without a sorting network.
  always_comb begin
    logic [3:0] rank;
    rank = '0;
    mid_sum = '0;
    for (int i = 0; i < N; i++) begin
      rank = '0;
      for (int j = 0; j < N; j++) begin
        if ((r_reg.smp[j] < r_reg.smp[i]) || ((r_reg.smp[j] == r_reg.smp[i]) && (j < i))) begin
          rank = rank + 4'h1;
        end
      end
      if ((rank >= 4'((N - MAV_MID) / 2)) && (rank < 4'((N + MAV_MID) / 2))) begin
        mid_sum = mid_sum + (W+2)'(r_reg.smp[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture and result formation.
  always_comb begin
    r_next = r_reg;
    r_next.out_valid = 1'b0;
    if (clear) begin
      r_next.cnt = '0;
      r_next.done = 1'b0;
    end else if (in_valid && need_more) begin
      r_next.smp[r_next.cnt[2:0]] = in_data;
      r_next.cnt = r_reg.cnt + 4'h1;
    end else if (!r_reg.done && (r_reg.cnt == need_cnt)) begin
      // Bypass passes the first sample through; the ranking still runs but is not used.
      r_next.done = 1'b1;
      r_next.out_valid = 1'b1;
      r_next.out_data = bypass ? r_reg.smp[0] : W'(mid_sum / (W+2)'(MAV_MID));
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : tpf_mav_filter

// *** hw/tpf_touch_ctrl.sv ***
/*
  Touch controller digital core: two-wire serial slave on the link clock,
  command decode, pen interrupt gating, conversion sequencing and the
  median-plus-average filter on the core clock.
  Assumes an analog front end that converts on request and reports done,
  and open-drain pads resolved outside from the output enables.

*/
`timescale 1ns/1ps
module tpf_touch_ctrl
  import tpf_pkg::*;
#(
  parameter int CONV12_CYC = CONV12_CYCLES,
  parameter int CONV8_CYC = CONV8_CYCLES
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Link clock, free running, oversamples the serial lines.
  input wire logic link_clk,
  // Serial bus pads.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address straps.
  input wire logic [1:0] addr_strap_pins,
  // Pen detect sense from the X-plus input and the interrupt pin.
  input wire logic xp_touch_sense,
  output logic pen_touch_irq_n,
  output logic irq_pullup_hi,
  output logic ym_drv_gnd,
  output logic xp_irq_route,
  output logic driver_only_on,
  // Converter control.
  output logic [3:0] function_select,
  output logic [1:0] power_mode_field,
  output logic adc_power_on,
  output logic conv_clk_fast,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ADC_W-1:0] adc_data,
  // Status.
  output logic conv_busy,
  output logic [ADC_W-1:0] result_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain state.
  typedef struct packed {
    logic [2:0] scl_s; // Bit 0 is the first synchroniser stage.
    logic [2:0] sda_s;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    tpf_link_st_t st;
    logic [3:0] cnt; // Bit count within the byte.
    logic [7:0] sh; // Receive and transmit shifter.
    logic rw; // Direction bit of the last matched address.
    logic oe; // Drives the data line low while set.
    logic nack; // Master answer to the last read byte.
    logic rd_idx; // Which half of the result goes next.
    logic [7:0] cmd; // Last received command byte.
    logic cmd_tgl;
    logic wra_tgl;
    logic xend_tgl;
    logic [2:0] res_s; // Result toggle synchroniser plus history.
    logic [ADC_W:0] res; // Mode bit and result, link copy.
  } tpf_link_t;

  // Core-domain state.
  typedef struct packed {
    logic [2:0] cmd_s;
    logic [2:0] wra_s;
    logic [2:0] xend_s;
    logic [1:0] xp_s;
    logic [3:0] fn;
    logic [1:0] pm;
    logic mode8;
    logic pullup_hi;
    logic bypass;
    logic pending; // Command waits for the closing condition.
    logic pen_en;
    logic drv_force;
    logic measuring;
    logic busy;
    logic wait_adc;
    logic have;
    logic [CONV_CNT_W-1:0] timer;
    logic [ADC_W-1:0] filt;
    logic [ADC_W-1:0] result;
    logic res_mode8;
    logic res_tgl;
    logic irq_n;
  } tpf_core_t;

  tpf_link_t l_reg;
  tpf_link_t l_next;
  tpf_core_t c_reg;
  tpf_core_t c_next;
  logic scl_rise; // Synchronised clock rose.
  logic scl_fall; // Synchronised clock fell.
  logic bus_start; // START or repeated START seen.
  logic bus_stop; // STOP seen.
  logic [7:0] tx_byte; // Next byte offered to a reading master.
  logic [7:0] cmd_core; // Command byte as seen from the core side.
  logic filt_clear; // Starts a new filter run.
  logic filt_need;
  logic filt_valid;
  logic [ADC_W-1:0] filt_data;
  logic [3:0] cur_fn; // Function of the captured command.

  ////////////////////////////////////////////////////////////////////////////
  // Link side. Lines are oversampled by the fast link clock, so the same
  // logic serves standard, fast and high-speed rates as long as each clock
  // phase spans a few link cycles.
  assign scl_rise = l_reg.scl_s[1] && !l_reg.scl_s[2];
  assign scl_fall = !l_reg.scl_s[1] && l_reg.scl_s[2];
  assign bus_start = l_reg.scl_s[1] && l_reg.scl_s[2] && l_reg.sda_s[2] && !l_reg.sda_s[1];
  assign bus_stop = l_reg.scl_s[1] && l_reg.scl_s[2] && !l_reg.sda_s[2] && l_reg.sda_s[1];

  // In 8-bit mode only the upper byte is meaningful, so it repeats.
  assign tx_byte = (l_reg.rd_idx && !l_reg.res[ADC_W]) ? {l_reg.res[3:0], 4'h0} : l_reg.res[ADC_W-1:4];

  // Pad drive is open drain: value fixed low, enable carries the data.
  assign sda_o = 1'b0;
  assign sda_oe = l_reg.oe;

  // Link-side next state.
  always_comb begin
    l_next = l_reg;
    l_next.scl_s = {l_reg.scl_s[1:0], scl_i};
    l_next.sda_s = {l_reg.sda_s[1:0], sda_i};
    l_next.strap_s1 = addr_strap_pins;
    l_next.strap_s2 = l_reg.strap_s1;
    l_next.res_s = {l_reg.res_s[1:0], c_reg.res_tgl};
    // The core updates its result with the toggle and holds it after, so it is safe here.
    if (l_reg.res_s[2] != l_reg.res_s[1]) begin
      l_next.res = {c_reg.res_mode8, c_reg.result};
    end
    if (bus_start) begin
      // A repeated START closes the old transfer and opens a new one.
      l_next.st = LK_ADDR;
      l_next.cnt = '0;
      l_next.oe = 1'b0;
      l_next.rd_idx = 1'b0;
      l_next.xend_tgl = !l_reg.xend_tgl;
    end else if (bus_stop) begin
      l_next.st = LK_IDLE;
      l_next.oe = 1'b0;
      l_next.xend_tgl = !l_reg.xend_tgl;
    end else begin
      case (l_reg.st)
        LK_ADDR, LK_RX: begin
          if (scl_rise) begin
            l_next.sh = {l_reg.sh[6:0], l_reg.sda_s[1]};
            l_next.cnt = l_reg.cnt + 4'h1;
          end else if (scl_fall && (l_reg.cnt == 4'h8)) begin
            if (l_reg.st == LK_RX) begin
              // Every written byte is taken and acknowledged.
              l_next.cmd = l_reg.sh;
              l_next.cmd_tgl = !l_reg.cmd_tgl;
              l_next.st = LK_RACK;
              l_next.oe = 1'b1;
            end else if (l_reg.sh[7:1] == {ADDR_FIXED, l_reg.strap_s2}) begin
              l_next.st = LK_AACK;
              l_next.oe = 1'b1;
              l_next.rw = l_reg.sh[0];
              if (!l_reg.sh[0]) begin
                l_next.wra_tgl = !l_reg.wra_tgl;
              end
            end else begin
              // Not our address: stay off the bus until the next condition.
              l_next.st = LK_WAIT;
            end
          end
        end
        LK_AACK, LK_RACK: begin
          if (scl_fall) begin
            l_next.cnt = '0;
            if (l_reg.rw) begin
              // Read direction: take over the data line.
              l_next.st = LK_TX;
              l_next.sh = tx_byte;
              l_next.oe = !tx_byte[7];
            end else begin
              l_next.st = LK_RX;
              l_next.oe = 1'b0;
            end
          end
        end
        LK_TX: begin
          if (scl_fall) begin
            l_next.sh = {l_reg.sh[6:0], 1'b0};
            l_next.cnt = l_reg.cnt + 4'h1;
            if (l_reg.cnt == 4'h7) begin
              l_next.oe = 1'b0;
              l_next.st = LK_TACK;
            end else begin
              l_next.oe = !l_reg.sh[6];
            end
          end
        end
        LK_TACK: begin
          if (scl_rise) begin
            l_next.nack = l_reg.sda_s[1];
          end else if (scl_fall) begin
            if (l_reg.nack) begin
              // Last byte: keep the line released for the master's STOP.
              l_next.st = LK_WAIT;
            end else begin
              l_next.st = LK_TX;
              l_next.cnt = '0;
              l_next.rd_idx = !l_reg.rd_idx;
              l_next.sh = (!l_reg.rd_idx && !l_reg.res[ADC_W]) ? {l_reg.res[3:0], 4'h0} : l_reg.res[ADC_W-1:4];
              l_next.oe = (!l_reg.rd_idx && !l_reg.res[ADC_W]) ? !l_reg.res[3] : !l_reg.res[ADC_W-1];
            end
          end
        end
        LK_IDLE, LK_WAIT: begin
          l_next.oe = 1'b0;
        end
        default: begin
          l_next.st = LK_IDLE;
          l_next.oe = 1'b0;
        end
      endcase
    end
  end

  // Link register.
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      l_reg <= '0;
      l_reg.scl_s <= 3'h7;
      l_reg.sda_s <= 3'h7;
    end else begin
      l_reg <= l_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side. The command byte is held by the link until the next byte has
  // fully arrived, many core cycles after its toggle, so the word is stable.
  assign cmd_core = l_reg.cmd;
  assign cur_fn = cmd_core[CMD_FN_LSB+3:CMD_FN_LSB];
  assign filt_clear = c_reg.pending && (c_reg.xend_s[2] != c_reg.xend_s[1]);

  // Core next state.
  always_comb begin
    c_next = c_reg;
    c_next.cmd_s = {c_reg.cmd_s[1:0], l_reg.cmd_tgl};
    c_next.wra_s = {c_reg.wra_s[1:0], l_reg.wra_tgl};
    c_next.xend_s = {c_reg.xend_s[1:0], l_reg.xend_tgl};
    c_next.xp_s = {c_reg.xp_s[0], xp_touch_sense};
    // Events are taken in this order so a late one overrides an early one.
    if (c_reg.wra_s[2] != c_reg.wra_s[1]) begin
      c_next.pen_en = 1'b0;
    end
    if (c_reg.cmd_s[2] != c_reg.cmd_s[1]) begin
      if (cur_fn == FN_SETUP) begin
        c_next.pullup_hi = cmd_core[SETUP_PULLUP_BIT];
        c_next.bypass = cmd_core[SETUP_BYPASS_BIT];
        // No conversion follows setup; detection returns per the held bit.
        c_next.pen_en = !c_reg.pm[0];
      end else begin
        c_next.fn = cur_fn;
        c_next.pm = cmd_core[CMD_PM_LSB+1:CMD_PM_LSB];
        c_next.mode8 = cmd_core[CMD_RES_BIT];
        c_next.pending = 1'b1;
      end
    end
    if (filt_clear) begin
      // The closing STOP or START starts the command.
      c_next.pending = 1'b0;
      c_next.pen_en = 1'b0;
      if ((c_reg.fn == FN_XDRV) || (c_reg.fn == FN_YDRV) || (c_reg.fn == FN_YXDRV)) begin
        c_next.drv_force = 1'b1;
      end else begin
        c_next.drv_force = 1'b0;
        c_next.busy = 1'b1;
        c_next.have = 1'b0;
        c_next.wait_adc = 1'b0;
        c_next.measuring = (c_reg.fn >= FN_MEAS_X);
        c_next.timer = c_reg.mode8 ? CONV_CNT_W'(CONV8_CYC) : CONV_CNT_W'(CONV12_CYC);
      end
    end else if (c_reg.busy) begin
      if (c_reg.timer != '0) begin
        c_next.timer = c_reg.timer - CONV_CNT_W'(1);
      end
      if (adc_start) begin
        c_next.wait_adc = 1'b1;
      end else if (adc_done) begin
        c_next.wait_adc = 1'b0;
      end
      if (filt_valid) begin
        c_next.have = 1'b1;
        c_next.filt = filt_data;
      end
      if (c_reg.have && (c_reg.timer == '0)) begin
        // Conversion over: publish the result and reopen detection unless pm bit 0 holds it off.
        c_next.busy = 1'b0;
        c_next.measuring = 1'b0;
        c_next.result = c_reg.filt;
        c_next.res_mode8 = c_reg.mode8;
        c_next.res_tgl = !c_reg.res_tgl;
        c_next.pen_en = !c_reg.pm[0];
      end
    end
    // Output pin: forced low by driver-only commands, silent when disabled.
    if (c_reg.drv_force) begin
      c_next.irq_n = 1'b0;
    end else if (c_reg.pen_en && !c_reg.measuring) begin
      c_next.irq_n = c_reg.xp_s[1];
    end else begin
      c_next.irq_n = 1'b1;
    end
  end

  // Core register.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      c_reg <= '0;
      c_reg.pm <= PM_RESET;
      c_reg.pullup_hi <= PULLUP_HI_RESET;
      c_reg.bypass <= BYPASS_RESET;
      c_reg.pen_en <= 1'b1;
      // The sense line idles high, so a cleared synchroniser would fake a touch.
      c_reg.xp_s <= 2'h3;
      c_reg.irq_n <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter over the run of conversions.
  tpf_mav_filter #(
    .W(ADC_W),
    .N(MAV_TAPS)
  ) u_filter (
    .clk(core_clk),
    .rst_n(rst_n),
    .clear(filt_clear),
    .bypass(c_reg.bypass),
    .in_valid(adc_done && c_reg.busy),
    .in_data(adc_data),
    .need_more(filt_need),
    .out_valid(filt_valid),
    .out_data(filt_data)
  );

  // One request at a time; the front end answers each with adc_done.
  assign adc_start = c_reg.busy && filt_need && !c_reg.wait_adc && !filt_clear;

  // Pin and status outputs.
  assign pen_touch_irq_n = c_reg.irq_n;
  assign irq_pullup_hi = c_reg.pullup_hi;
  assign ym_drv_gnd = c_reg.pen_en && !c_reg.busy;
  assign xp_irq_route = c_reg.pen_en && !c_reg.measuring;
  assign driver_only_on = c_reg.drv_force;
  assign function_select = c_reg.fn;
  assign power_mode_field = c_reg.pm;
  assign adc_power_on = c_reg.busy || c_reg.pm[0];
  assign conv_clk_fast = c_reg.mode8;
  assign conv_busy = c_reg.busy;
  assign result_data = c_reg.result;

endmodule : tpf_touch_ctrl

// *** sim/tpf_touch_ctrl_props.sv ***
/*
  Checker for the touch controller core, watching its ports only.
  Assumes it is bound to tpf_touch_ctrl with the same timer parameters.
*/
`timescale 1ns/1ps
module tpf_touch_ctrl_props
  import tpf_pkg::*;
#(
  parameter int CONV12_CYC = CONV12_CYCLES,
  parameter int CONV8_CYC = CONV8_CYCLES
) (
  // Clocks and reset.
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  // Serial side.
  input wire logic scl_i,
  input wire logic sda_oe,
  // Pen and converter side.
  input wire logic pen_touch_irq_n,
  input wire logic irq_pullup_hi,
  input wire logic xp_irq_route,
  input wire logic driver_only_on,
  input wire logic [3:0] function_select,
  input wire logic [1:0] power_mode_field,
  input wire logic adc_power_on,
  input wire logic conv_clk_fast,
  input wire logic adc_start,
  input wire logic conv_busy
);
  // Cycles spent busy so far; a counter avoids long repetitions.
  int busy_cnt;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !conv_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n)
    $changed(sda_oe) |-> !scl_i) else $error("data drive changed with clock high");
  a_reset_clear: assert property (@(posedge core_clk)
    !rst_n |=> !conv_busy && irq_pullup_hi == PULLUP_HI_RESET) else $error("reset state wrong");
  a_start_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    adc_start |=> !adc_start) else $error("conversion request longer than one cycle");
  a_driver_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    driver_only_on && $past(driver_only_on) |-> !pen_touch_irq_n) else $error("pen not forced low");
  a_meas_open: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_busy && $past(conv_busy) && function_select[3:2] == 2'h3 |-> !xp_irq_route)
    else $error("sense input routed while measuring");
  a_hold_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    power_mode_field[0] && $past(power_mode_field[0]) && !driver_only_on && !$past(driver_only_on)
    |-> pen_touch_irq_n) else $error("pen active with driver hold set");
  a_power_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    power_mode_field[0] |-> adc_power_on) else $error("converter off in powered mode");
  a_busy_min: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(conv_busy) |-> busy_cnt >= (conv_clk_fast ? CONV8_CYC : CONV12_CYC) - 2)
    else $error("conversion ended early");
  a_busy_max: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_busy |-> busy_cnt < CONV12_CYC + 400) else $error("conversion never ends");
endmodule : tpf_touch_ctrl_props

// *** sim/tpf_bus_master.sv ***
/*
  Serial bus master model: makes the clock, START, STOP and bytes.
  Assumes the bench resolves the open-drain data line; a phase is two core cycles.
*/
`timescale 1ns/1ps
module tpf_bus_master (
  // Timing reference.
  input wire logic core_clk,
  // Bus lines.
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // Both lines idle high before the first transfer.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One phase spans well over four link cycles.
  task automatic ph;
    repeat (2) @(posedge core_clk);
  endtask : ph
  // START, also a repeated START from clock low.
  task automatic start;
    @(posedge core_clk);
    sda <= 1'b1;
    ph;
    scl <= 1'b1;
    ph;
    sda <= 1'b0;
    ph;
    scl <= 1'b0;
  endtask : start
  // STOP releases the bus.
  task automatic stop;
    @(posedge core_clk);
    sda <= 1'b0;
    ph;
    scl <= 1'b1;
    ph;
    sda <= 1'b1;
    ph;
  endtask : stop
  // Eight bits plus the ninth acknowledge clock; data moves only with clock low.
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ar);
    logic [8:0] s;
    s = {d, a};
    for (int i = 8; i >= 0; i--) begin
      @(posedge core_clk);
      sda <= s[i];
      ph;
      scl <= 1'b1;
      ph;
      s[i] = sda_line;
      scl <= 1'b0;
    end
    q = s[8:1];
    ar = s[0];
  endtask : xfer
endmodule : tpf_bus_master

// *** sim/testbench.sv ***
/*
  Testbench for the touch controller core: bus master, converter model, tests.
  Assumes the design package and core are compiled first.
*/
`timescale 1ns/1ps
module testbench
  import tpf_pkg::*;
;
  localparam int CONV12_CYC = 40;
  localparam int CONV8_CYC = 20;
  logic core_clk, link_clk, rst_n, scl, sda_m, sda_o, sda_oe, xp_touch_sense, adc_done, adc_start;
  logic pen_touch_irq_n, irq_pullup_hi, ym_drv_gnd, xp_irq_route, driver_only_on;
  logic adc_power_on, conv_clk_fast, conv_busy, ak;
  logic [11:0] adc_data, result_data;
  logic [3:0] function_select;
  logic [1:0] power_mode_field, addr_strap_pins;
  logic [7:0] q;
  int err_total, tests_run, idx;
  // Seven samples; middle three are 12C, 191, 1F4 with a truncated mean of 190.
  logic [11:0] smp [7] = '{12'h064, 12'h384, 12'h12C, 12'h1F4, 12'h0C8, 12'h2BC, 12'h191};
  // Open-drain data line with a pull-up.
  wire sda_line = sda_m & ~sda_oe;
  tpf_touch_ctrl #(.CONV12_CYC(CONV12_CYC), .CONV8_CYC(CONV8_CYC)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_pins(addr_strap_pins), .xp_touch_sense(xp_touch_sense), .pen_touch_irq_n(pen_touch_irq_n),
    .irq_pullup_hi(irq_pullup_hi), .ym_drv_gnd(ym_drv_gnd), .xp_irq_route(xp_irq_route),
    .driver_only_on(driver_only_on), .function_select(function_select), .power_mode_field(power_mode_field),
    .adc_power_on(adc_power_on), .conv_clk_fast(conv_clk_fast), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .conv_busy(conv_busy), .result_data(result_data));
  tpf_bus_master u_bus (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Link clock of unrelated phase, so no edge meets a core edge.
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  // Converter front end: answers each request one cycle later.
  always @(posedge core_clk) begin
    adc_done <= adc_start;
    if (adc_start) begin
      adc_data <= smp[idx % 7];
      idx <= idx + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic nw(input int n);
    repeat (n) @(negedge core_clk);
  endtask : nw
  task automatic endt(input int n);
    $display("test %0d done", n);
  endtask : endt
  // Write one command; a repeated START may follow instead of STOP.
  // The pen interrupt must read high after the write address, as the core turns detection off.
  task automatic wr(input logic [7:0] c, input logic stp);
    u_bus.start;
    u_bus.xfer({ADDR_FIXED, 2'h1, 1'b0}, 1'b1, q, ak);
    nw(1);
    chk(12'(ak), 12'h0);
    if (!xp_touch_sense) chk(12'(pen_touch_irq_n), 12'h1);
    u_bus.xfer(c, 1'b1, q, ak);
    nw(1);
    chk(12'(ak), 12'h0);
    idx = 0;
    if (stp) u_bus.stop;
  endtask : wr
  task automatic conv_wait;
    int n;
    n = 0;
    nw(10);
    while (conv_busy !== 1'b0 && n < 3000) begin
      nw(1);
      n++;
    end
    chk(12'(conv_busy), 12'h0);
  endtask : conv_wait
  task automatic final_report;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // The whole run takes some 25 us; far longer means a hang.
  initial begin
    repeat (25000) @(posedge core_clk);
    err_total++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    xp_touch_sense = 1'b1;
    adc_done = 1'b0;
    adc_data = 12'h000;
    addr_strap_pins = 2'h1;
    idx = 0;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    nw(8);
    chk(12'(pen_touch_irq_n), 12'h1);
    chk(12'(irq_pullup_hi), 12'h0);
    chk(12'({ym_drv_gnd, xp_irq_route}), 12'h3);
    @(posedge core_clk) xp_touch_sense <= 1'b0;
    nw(6);
    chk(12'(pen_touch_irq_n), 12'h0);
    endt(1);
    wr(8'hB1, 1'b1);
    nw(4);
    chk(12'(irq_pullup_hi), 12'h1);
    wr(8'hB0, 1'b1);
    nw(4);
    chk(12'(irq_pullup_hi), 12'h0);
    endt(2);
    wr(8'hC0, 1'b1);
    nw(10);
    chk(12'({conv_busy, xp_irq_route, pen_touch_irq_n}), 12'h5);
    conv_wait;
    chk(result_data, 12'h190);
    nw(6);
    chk(12'(pen_touch_irq_n), 12'h0);
    endt(3);
    u_bus.start;
    u_bus.xfer({ADDR_FIXED, 2'h1, 1'b1}, 1'b1, q, ak);
    chk(12'(ak), 12'h0);
    u_bus.xfer(8'hFF, 1'b0, q, ak);
    chk(12'(q), 12'h019);
    u_bus.xfer(8'hFF, 1'b1, q, ak);
    chk(12'(q), 12'h000);
    nw(3);
    chk(12'(sda_oe), 12'h0);
    u_bus.stop;
    endt(4);
    wr(8'hC4, 1'b1);
    conv_wait;
    nw(4);
    chk(12'({pen_touch_irq_n, adc_power_on}), 12'h3);
    chk(12'({function_select, power_mode_field}), 12'h031);
    endt(5);
    @(posedge core_clk) xp_touch_sense <= 1'b1;
    wr(8'h80, 1'b1);
    conv_wait;
    chk(12'({driver_only_on, pen_touch_irq_n}), 12'h2);
    endt(6);
    u_bus.start;
    u_bus.xfer({ADDR_FIXED, 2'h2, 1'b0}, 1'b1, q, ak);
    chk(12'(ak), 12'h1);
    u_bus.stop;
    endt(7);
    wr(8'hB2, 1'b1);
    wr(8'hC2, 1'b0);
    u_bus.start;
    u_bus.xfer({ADDR_FIXED, 2'h1, 1'b1}, 1'b1, q, ak);
    chk(12'(ak), 12'h0);
    u_bus.xfer(8'hFF, 1'b1, q, ak);
    u_bus.stop;
    conv_wait;
    chk(result_data, 12'h064);
    chk(12'(conv_clk_fast), 12'h1);
    endt(8);
    final_report;
  end
endmodule : testbench

bind tpf_touch_ctrl tpf_touch_ctrl_props #(.CONV12_CYC(CONV12_CYC), .CONV8_CYC(CONV8_CYC)) u_props (
  .core_clk, .link_clk, .rst_n, .scl_i, .sda_oe, .pen_touch_irq_n, .irq_pullup_hi, .xp_irq_route,
  .driver_only_on, .function_select, .power_mode_field, .adc_power_on, .conv_clk_fast, .adc_start, .conv_busy);
